// ### mmb_defines.svh
// Constants for the minimum-mode bus control block.
`ifndef MMB_DEFINES_SVH
`define MMB_DEFINES_SVH

`define MMB_ADDR_W      20
`define MMB_DATA_W      8
`define MMB_CODE_W      3

// Cycle codes as {io_mem, xcvr_direction, cycle_status_0}.
`define MMB_CYC_IRQ_ACK_STROBE_N    3'h4
`define MMB_CYC_IORD    3'h5
`define MMB_CYC_IOWR    3'h6
`define MMB_CYC_HALT    3'h7
`define MMB_CYC_CODE    3'h0
`define MMB_CYC_MEMRD   3'h1
`define MMB_CYC_MEMWR   3'h2
`define MMB_CYC_PASSIVE 3'h3

// Bit positions inside a cycle code.
`define MMB_BIT_IOM     2
`define MMB_BIT_DIR     1
`define MMB_BIT_SS0     0

// Control pin slots in the shared release vector.
`define MMB_PIN_IOM     0
`define MMB_PIN_DIR     1
`define MMB_PIN_EN      2
`define MMB_PIN_SS0     3
`define MMB_PIN_WR      4
`define MMB_PIN_IRQ     5
`define MMB_PIN_COUNT   6

// Level shown by a released control pin, standing in for the weak bus-hold one.
`define MMB_FLOAT_LVL   1'h1

`endif

// ### mmb_pkg.sv
// Types shared by the minimum-mode bus control block.
`include "mmb_defines.svh"

package mmb_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRE  = 3'b001,
    ST_T1   = 3'b010,
    ST_T2   = 3'b011,
    ST_T3   = 3'b100,
    ST_TW   = 3'b101,
    ST_T4   = 3'b110,
    ST_HALT = 3'b111
  } mmb_state_t;

  typedef logic [`MMB_CODE_W-1:0] mmb_code_t;

  typedef struct packed {
    mmb_state_t             state;
    logic                   half;
    mmb_code_t              code;
    logic [`MMB_ADDR_W-1:0] addr;
    logic [`MMB_DATA_W-1:0] wdata;
    logic [`MMB_DATA_W-1:0] rdata;
    logic                   rsp_valid;
    logic                   released;
  } mmb_regs_t;

endpackage : mmb_pkg

// ### mmb_hold_ctl.sv
// Hold request and acknowledge handshake with an alternate bus master.
`timescale 1ns/1ns

module mmb_hold_ctl
  import mmb_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic min_mode_i,
  input  wire logic hold_req_i,
  input  wire logic grant_window_i,
  output logic      hold_ack_o
);

  typedef struct packed {
    logic ack;
  } mmb_hold_regs_t;

  mmb_hold_regs_t hold_reg;
  mmb_hold_regs_t hold_next;

  always_comb begin
    hold_next = hold_reg;
    if (!min_mode_i) begin
      hold_next.ack = 1'b0;
    end else if (!hold_ack_o) begin
      if (hold_req_i && grant_window_i) begin
        hold_next.ack = 1'b1;
      end
    end else if (!hold_req_i) begin
      hold_next.ack = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_reg <= '0;
    end else begin
      hold_reg <= hold_next;
    end
  end

  assign hold_ack_o = hold_reg.ack;

endmodule : mmb_hold_ctl

// ### mmb_bus_ctrl.sv
// Minimum-mode local bus control: strobes, transceiver control, status and hold.
`timescale 1ns/1ns

`include "mmb_defines.svh"

module mmb_bus_ctrl
  import mmb_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   min_max_strap_i,
  input  wire logic                   req_valid_i,
  input  wire mmb_pkg::mmb_code_t     req_code_i,
  input  wire logic [`MMB_ADDR_W-1:0] req_addr_i,
  input  wire logic [`MMB_DATA_W-1:0] req_wdata_i,
  output logic                        req_ready_o,
  output logic                        rsp_valid_o,
  output logic [`MMB_DATA_W-1:0]      rsp_rdata_o,
  input  wire logic                   bus_ready_i,
  input  wire logic                   hold_req_i,
  output logic                        hold_ack_o,
  output logic                        ale_o,
  output logic [`MMB_ADDR_W-1:0]      addr_o,
  output logic                        addr_oe_n_o,
  output logic [`MMB_DATA_W-1:0]      ad_o,
  output logic                        ad_oe_n_o,
  input  wire logic [`MMB_DATA_W-1:0] ad_i,
  output logic                        io_mem_o,
  output logic                        io_mem_oe_n_o,
  output logic                        xcvr_direction_o,
  output logic                        xcvr_direction_oe_n_o,
  output logic                        xcvr_enable_n_o,
  output logic                        xcvr_enable_n_oe_n_o,
  output logic                        cycle_status_0_o,
  output logic                        cycle_status_0_oe_n_o,
  output logic                        wr_n_o,
  output logic                        wr_n_oe_n_o,
  output logic                        irq_ack_strobe_n_o,
  output logic                        irq_ack_strobe_n_oe_n_o
);

  import mmb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  mmb_regs_t st_reg;
  mmb_regs_t st_next;
  logic      min_mode;
  logic      grant_window;
  logic      released;
  logic      is_write;
  logic      is_irq_ack_strobe_n;
  logic      uses_xcvr;
  logic      in_cycle;
  logic      in_data;
  logic      start_ok;
  logic      at_boundary;
  logic      take_cycle;
  logic      t2_late;
  logic      t4_early;
  logic      data_phase;
  logic      wr_window;
  logic      rd_window;
  logic      enable_on;

  logic [`MMB_PIN_COUNT-1:0] ctl_level;
  logic [`MMB_PIN_COUNT-1:0] ctl_pin;
  logic [`MMB_PIN_COUNT-1:0] ctl_oe_n;

  assign min_mode = min_max_strap_i;

  // A cycle may only start, and the bus may only be granted, between cycles.
  assign at_boundary = st_reg.state == ST_IDLE || st_reg.state == ST_T4;

  // first half of T4 or idle
  assign grant_window = !st_reg.half && at_boundary;

  mmb_hold_ctl u_hold (
    .ref_clk_i      (ref_clk_i),
    .rst_i          (rst_i),
    .min_mode_i     (min_mode),
    .hold_req_i     (hold_req_i),
    .grant_window_i (grant_window),
    .hold_ack_o     (hold_ack_o)
  );

  assign released = !min_mode || hold_ack_o || st_reg.released;

  assign is_write  = st_reg.code == `MMB_CYC_MEMWR || st_reg.code == `MMB_CYC_IOWR;
  assign is_irq_ack_strobe_n   = st_reg.code == `MMB_CYC_IRQ_ACK_STROBE_N;
  assign uses_xcvr = st_reg.code != `MMB_CYC_HALT && st_reg.code != `MMB_CYC_PASSIVE;
  assign in_cycle  = st_reg.state != ST_IDLE;
  assign in_data   = st_reg.state == ST_T2 || st_reg.state == ST_T3 || st_reg.state == ST_TW;

  assign start_ok = min_mode && st_reg.half && !hold_ack_o && !hold_req_i && at_boundary;

  // A passive code is accepted but runs no cycle, so no latch strobe goes out.
  assign take_cycle = start_ok && req_valid_i && req_code_i != `MMB_CYC_PASSIVE;

  assign req_ready_o = start_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Each clock state is two clock cycles, so the half bit marks its middle.

  always_comb begin
    st_next           = st_reg;
    st_next.half      = !st_reg.half;
    st_next.rsp_valid = 1'b0;
    if (hold_ack_o) begin
      st_next.released = 1'b1;
    end
    if (!min_mode) begin
      st_next.state = ST_IDLE;
      st_next.half  = 1'b0;
    end else if (st_reg.half) begin
      unique case (st_reg.state)
        ST_IDLE, ST_T4: begin
          st_next.state = ST_IDLE;
          if (st_reg.state == ST_T4) begin
            st_next.code = {st_reg.code[`MMB_BIT_IOM], 2'h3};
          end
          if (take_cycle) begin
            st_next.code     = req_code_i;
            st_next.addr     = req_addr_i;
            st_next.wdata    = req_wdata_i;
            st_next.released = 1'b0;
            st_next.state    = (st_reg.state == ST_T4) ? ST_T1 : ST_PRE;
          end
        end
        ST_PRE:  st_next.state = ST_T1;
        ST_T1:   st_next.state = (st_reg.code == `MMB_CYC_HALT) ? ST_HALT : ST_T2;
        ST_T2:   st_next.state = ST_T3;
        ST_T3, ST_TW: begin
          if (bus_ready_i) begin
            st_next.state = ST_T4;
            if (!is_write) begin
              st_next.rdata     = ad_i;
              st_next.rsp_valid = 1'b1;
            end
          end else begin
            st_next.state = ST_TW;
          end
        end
        ST_HALT: begin
          // A halted bus returns to idle after one clock state, with no hold or request needed.
          st_next.state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg       <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.code  <= `MMB_CYC_PASSIVE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode. Released control pins show the weak one; all released pins drop their enables.

  assign rsp_valid_o = st_reg.rsp_valid;
  assign rsp_rdata_o = st_reg.rdata;

  assign t2_late    = st_reg.state == ST_T2 && st_reg.half;
  assign t4_early   = st_reg.state == ST_T4 && !st_reg.half;
  assign data_phase = in_data || st_reg.state == ST_T4;

  assign wr_window = is_write && (in_data || t4_early);
  assign rd_window = !is_write && (t2_late || st_reg.state == ST_T3
                     || st_reg.state == ST_TW || t4_early);
  assign enable_on = uses_xcvr && in_cycle && (wr_window || rd_window);

  // strobe in first half of T1
  assign ale_o = min_mode && !hold_ack_o && st_reg.state == ST_T1 && !st_reg.half;

  ////////////////////////////////////////////////////////////////////////////
  // Multiplexed lines. A read leaves the byte lanes undriven from T2 to T4,
  // so the device never fights the peripheral that answers it.

  always_comb begin
    addr_o      = st_reg.addr;
    addr_oe_n_o = released;
    ad_o        = st_reg.addr[`MMB_DATA_W-1:0];
    ad_oe_n_o   = released;
    if (!released && data_phase) begin
      if (is_write) begin
        ad_o = st_reg.wdata;
      end else begin
        ad_oe_n_o = 1'b1;
        ad_o      = `MMB_DATA_W'(0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control pins. All six share one release rule, so their driven levels
  // are gathered in a vector and floated by one loop.

  always_comb begin
    ctl_level[`MMB_PIN_IOM] = st_reg.code[`MMB_BIT_IOM];
    ctl_level[`MMB_PIN_DIR] = st_reg.code[`MMB_BIT_DIR];
    ctl_level[`MMB_PIN_EN]  = !enable_on;
    ctl_level[`MMB_PIN_SS0] = st_reg.code[`MMB_BIT_SS0];
    ctl_level[`MMB_PIN_WR]  = !(is_write && in_data);
    ctl_level[`MMB_PIN_IRQ] = !(is_irq_ack_strobe_n && in_data);
  end

  generate
    for (genvar pin_idx = 0; pin_idx < `MMB_PIN_COUNT; pin_idx++) begin : g_ctl_pin
      assign ctl_pin[pin_idx]  = released ? `MMB_FLOAT_LVL : ctl_level[pin_idx];
      assign ctl_oe_n[pin_idx] = released;
    end
  endgenerate

  assign io_mem_o                = ctl_pin[`MMB_PIN_IOM];
  assign io_mem_oe_n_o           = ctl_oe_n[`MMB_PIN_IOM];
  assign xcvr_direction_o        = ctl_pin[`MMB_PIN_DIR];
  assign xcvr_direction_oe_n_o   = ctl_oe_n[`MMB_PIN_DIR];
  assign xcvr_enable_n_o         = ctl_pin[`MMB_PIN_EN];
  assign xcvr_enable_n_oe_n_o    = ctl_oe_n[`MMB_PIN_EN];
  assign cycle_status_0_o        = ctl_pin[`MMB_PIN_SS0];
  assign cycle_status_0_oe_n_o   = ctl_oe_n[`MMB_PIN_SS0];
  assign wr_n_o                  = ctl_pin[`MMB_PIN_WR];
  assign wr_n_oe_n_o             = ctl_oe_n[`MMB_PIN_WR];
  assign irq_ack_strobe_n_o      = ctl_pin[`MMB_PIN_IRQ];
  assign irq_ack_strobe_n_oe_n_o = ctl_oe_n[`MMB_PIN_IRQ];

endmodule : mmb_bus_ctrl

// ### mmb_bus_ctrl_monitor.sv
// Concurrent checks on the ports of the minimum-mode bus control block.
`timescale 1ns/1ns
`include "mmb_defines.svh"
module mmb_bus_ctrl_chk
  import mmb_pkg::*;
(
  input wire logic               ref_clk_i,
  input wire logic               rst_i,
  input wire logic               min_max_strap_i,
  input wire logic               req_valid_i,
  input wire mmb_pkg::mmb_code_t req_code_i,
  input wire logic               req_ready_o,
  input wire logic               rsp_valid_o,
  input wire logic               hold_req_i,
  input wire logic               hold_ack_o,
  input wire logic               ale_o,
  input wire logic               io_mem_o,
  input wire logic               io_mem_oe_n_o,
  input wire logic               xcvr_direction_o,
  input wire logic               xcvr_direction_oe_n_o,
  input wire logic               xcvr_enable_n_o,
  input wire logic               xcvr_enable_n_oe_n_o,
  input wire logic               cycle_status_0_o,
  input wire logic               cycle_status_0_oe_n_o,
  input wire logic               wr_n_o,
  input wire logic               wr_n_oe_n_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  a_ack_rise: assert property ($rose(hold_ack_o) |-> $past(hold_req_i))
    else $error("hold ack rose without a request");
  a_ack_drop: assert property (hold_ack_o && !hold_req_i |=> !hold_ack_o)
    else $error("hold ack kept after request fell");
  a_dir_float: assert property (hold_ack_o |-> xcvr_direction_oe_n_o && xcvr_direction_o)
    else $error("direction driven in hold");
  a_en_float: assert property (hold_ack_o |-> xcvr_enable_n_oe_n_o && xcvr_enable_n_o)
    else $error("enable driven in hold");
  a_ss0_float: assert property (hold_ack_o |-> cycle_status_0_oe_n_o && cycle_status_0_o)
    else $error("status driven in hold");
  a_ctl_float: assert property (hold_ack_o |-> wr_n_oe_n_o && wr_n_o && io_mem_oe_n_o)
    else $error("control driven in hold");
  a_hold_quiet: assert property (hold_ack_o |-> !ale_o && !req_ready_o)
    else $error("cycle activity in hold");
  a_rd_enable: assert property ($rose(ale_o) && !xcvr_direction_o
    |-> ##3 $fell(xcvr_enable_n_o))
    else $error("read enable not at mid T2");
  a_wr_enable: assert property ($rose(ale_o) && xcvr_direction_o && !cycle_status_0_o
    |-> ##2 ($fell(xcvr_enable_n_o) && $fell(wr_n_o)))
    else $error("write enable not at start of T2");
  a_rd_end: assert property ($rose(rsp_valid_o) |-> !xcvr_enable_n_o ##1 xcvr_enable_n_o)
    else $error("read enable not ended mid T4");
  a_wr_end: assert property ($rose(wr_n_o) |-> !xcvr_enable_n_o ##1 xcvr_enable_n_o)
    else $error("write enable not ended mid T4");
  a_code_hold: assert property ($rose(ale_o) && !(xcvr_direction_o && cycle_status_0_o)
    |-> ##1 $stable({io_mem_o, xcvr_direction_o})[*6])
    else $error("cycle status changed in cycle");
  a_code_issue: assert property (req_valid_i && req_ready_o && req_code_i != `MMB_CYC_PASSIVE
    |-> ##2 {io_mem_o, xcvr_direction_o, cycle_status_0_o} == $past(req_code_i, 2))
    else $error("cycle code differs from request");
  a_strap_off: assert property (!min_max_strap_i && !$past(min_max_strap_i)
    |-> !ale_o && !hold_ack_o && !req_ready_o && xcvr_direction_oe_n_o)
    else $error("activity outside minimum mode");
endmodule : mmb_bus_ctrl_chk

bind mmb_bus_ctrl mmb_bus_ctrl_chk chk_u (.ref_clk_i, .rst_i, .min_max_strap_i, .req_valid_i,
  .req_code_i, .req_ready_o, .rsp_valid_o, .hold_req_i, .hold_ack_o, .ale_o, .io_mem_o,
  .io_mem_oe_n_o, .xcvr_direction_o, .xcvr_direction_oe_n_o, .xcvr_enable_n_o,
  .xcvr_enable_n_oe_n_o, .cycle_status_0_o, .cycle_status_0_oe_n_o, .wr_n_o, .wr_n_oe_n_o);

// ### mmb_bus_partner.sv
// Far-side model: address latch, transceiver target and alternate bus master.
`timescale 1ns/1ns
module mmb_bus_partner (
  input  logic        ref_clk_i,
  input  logic        ale_i,
  input  logic [19:0] addr_i,
  input  logic        dir_i,
  input  logic        en_n_i,
  input  logic        wr_n_i,
  input  logic [7:0]  wdat_i,
  input  int          waits_i,
  input  logic        want_i,
  output logic [7:0]  rdat_o,
  output logic        ready_o,
  output logic        hold_req_o,
  output logic [7:0]  wcap_o
);
  logic [19:0] lat;
  logic [7:0]  last = 8'h00;
  int          cnt = 0;
  initial hold_req_o = 1'b0;
  ////////////////////////////////////////
  // latch the address.
  always @(posedge ref_clk_i) begin
    if (ale_i) lat <= addr_i;
    cnt <= ale_i ? 0 : cnt + 1;
    last <= rdat_o;
    if (!wr_n_i) wcap_o <= wdat_i;
  end
  // drive only when enabled inward; otherwise a changing pattern.
  assign rdat_o = (!en_n_i && !dir_i) ? lat[7:0] ^ 8'h3c : ~last;
  assign ready_o = cnt >= 4 + 2 * waits_i;
  always @(posedge ref_clk_i) hold_req_o <= want_i;
endmodule : mmb_bus_partner

// ### mmb_bus_ctrl_test.sv
// Self-checking testbench for the minimum-mode bus control block.
`timescale 1ns/1ns
`include "mmb_defines.svh"
module mmb_bus_ctrl_test;
  import mmb_pkg::*;
  logic                   rst_i = 1, min_max_strap_i = 1, req_valid_i = 0, want = 0, ref_clk_i;
  mmb_code_t              req_code_i = `MMB_CYC_PASSIVE;
  logic [`MMB_ADDR_W-1:0] req_addr_i = 0, addr_o;
  logic [`MMB_DATA_W-1:0] req_wdata_i = 0, rsp_rdata_o, ad_o, ad_i, wcap;
  logic                   bus_ready_i, hold_req_i, req_ready_o, rsp_valid_o, hold_ack_o, ale_o;
  logic                   addr_oe_n_o, ad_oe_n_o, io_mem_o, io_mem_oe_n_o, xcvr_direction_o;
  logic                   xcvr_direction_oe_n_o, xcvr_enable_n_o, xcvr_enable_n_oe_n_o;
  logic                   cycle_status_0_o, cycle_status_0_oe_n_o, wr_n_o, wr_n_oe_n_o;
  logic                   irq_ack_strobe_n_o, irq_ack_strobe_n_oe_n_o;
  int                     waits = 0, mismatches = 0, checks_done = 0;
  logic [7:0]             rq[$];
  ////////////////////////////////////////
  mmb_bus_ctrl dut_u (.ref_clk_i, .rst_i, .min_max_strap_i, .req_valid_i, .req_code_i,
    .req_addr_i, .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .bus_ready_i,
    .hold_req_i, .hold_ack_o, .ale_o, .addr_o, .addr_oe_n_o, .ad_o, .ad_oe_n_o, .ad_i,
    .io_mem_o, .io_mem_oe_n_o, .xcvr_direction_o, .xcvr_direction_oe_n_o, .xcvr_enable_n_o,
    .xcvr_enable_n_oe_n_o, .cycle_status_0_o, .cycle_status_0_oe_n_o, .wr_n_o, .wr_n_oe_n_o,
    .irq_ack_strobe_n_o, .irq_ack_strobe_n_oe_n_o);
  mmb_bus_partner far_u (.ref_clk_i, .ale_i(ale_o), .addr_i(addr_o), .dir_i(xcvr_direction_o),
    .en_n_i(xcvr_enable_n_o), .wr_n_i(wr_n_o), .wdat_i(ad_o), .waits_i(waits), .want_i(want),
    .rdat_o(ad_i), .ready_o(bus_ready_i), .hold_req_o(hold_req_i), .wcap_o(wcap));
  initial begin
    ref_clk_i = 0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // The data pulse stands one cycle, so it is queued where it is seen.
  always @(negedge ref_clk_i) if (rsp_valid_o === 1'b1) rq.push_back(rsp_rdata_o);
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task chk(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tmo;
    chk(1'b0, 1'b1);
    finish_test();
  endtask : tmo
  task send(input mmb_code_t c, input logic [19:0] a, input logic [7:0] d, input bit keep);
    int i;
    @(negedge ref_clk_i);
    req_valid_i = 1;
    req_code_i = c;
    req_addr_i = a;
    req_wdata_i = d;
    for (i = 0; i < 40 && req_ready_o !== 1'b1; i++) @(negedge ref_clk_i);
    if (req_ready_o !== 1'b1) tmo();
    @(posedge ref_clk_i);
    if (!keep) begin
      @(negedge ref_clk_i);
      req_valid_i = 0;
    end
  endtask : send
  task run_cycle(input mmb_code_t c, input logic [19:0] a, input logic [7:0] d);
    int i;
    bit wr;
    wr = c[1] && !c[0];
    send(c, a, d, 1'b0);
    for (i = 0; i < 12 && ale_o !== 1'b1; i++) @(negedge ref_clk_i);
    if (c == `MMB_CYC_PASSIVE) chk(ale_o, 1'b0);
    else begin
      if (ale_o !== 1'b1) tmo();
      chk({io_mem_oe_n_o, io_mem_o, xcvr_direction_o, cycle_status_0_o}, {1'b0, c});
      repeat (2) @(negedge ref_clk_i);
      chk({ad_oe_n_o, wr_n_o, xcvr_enable_n_o}, {!c[1], !wr, !wr});
      chk(irq_ack_strobe_n_o, c != `MMB_CYC_IRQ_ACK_STROBE_N);
    end
    if (!c[1]) begin
      for (i = 0; i < 30 && rq.size() == 0; i++) @(negedge ref_clk_i);
      if (rq.size() == 0) tmo();
      chk(rq.pop_front(), a[7:0] ^ 8'h3c);
    end
    if (c[1] && !c[0]) begin
      repeat (10) @(negedge ref_clk_i);
      chk(wcap, d);
    end
    repeat (4) @(negedge ref_clk_i);
  endtask : run_cycle
  task t_codes;
    int c;
    for (c = 0; c < 8; c++) begin
      waits = c % 2;
      run_cycle(c[2:0], 20'h5a5a0 + c, 8'h96 ^ c[7:0]);
    end
    $display("test codes done");
  endtask : t_codes
  task t_b2b;
    int i;
    waits = 0;
    send(`MMB_CYC_MEMRD, 20'h12345, 8'h00, 1'b1);
    send(`MMB_CYC_IORD, 20'h0006a, 8'h00, 1'b0);
    for (i = 0; i < 40 && rq.size() < 2; i++) @(negedge ref_clk_i);
    if (rq.size() < 2) tmo();
    chk(rq.pop_front(), 8'h45 ^ 8'h3c);
    chk(rq.pop_front(), 8'h6a ^ 8'h3c);
    $display("test b2b done");
  endtask : t_b2b
  task t_hold;
    int i;
    want = 1;
    for (i = 0; i < 20 && hold_ack_o !== 1'b1; i++) @(negedge ref_clk_i);
    if (hold_ack_o !== 1'b1) tmo();
    req_valid_i = 1;
    repeat (4) begin
      @(negedge ref_clk_i);
      chk({xcvr_direction_oe_n_o, xcvr_direction_o, xcvr_enable_n_oe_n_o, xcvr_enable_n_o,
        cycle_status_0_oe_n_o, cycle_status_0_o}, 6'h3f);
      chk({ad_oe_n_o, addr_oe_n_o, wr_n_oe_n_o, wr_n_o, irq_ack_strobe_n_oe_n_o,
        irq_ack_strobe_n_o, req_ready_o, ale_o}, 8'hfc);
    end
    req_valid_i = 0;
    want = 0;
    for (i = 0; i < 10 && hold_ack_o !== 1'b0; i++) @(negedge ref_clk_i);
    if (hold_ack_o !== 1'b0) tmo();
    run_cycle(`MMB_CYC_MEMWR, 20'h0f0f0, 8'hc3);
    $display("test hold done");
  endtask : t_hold
  task t_strap;
    min_max_strap_i = 0;
    repeat (3) @(negedge ref_clk_i);
    chk({req_ready_o, ale_o, hold_ack_o, xcvr_direction_oe_n_o, wr_n_oe_n_o}, 5'h03);
    min_max_strap_i = 1;
    run_cycle(`MMB_CYC_IOWR, 20'h00321, 8'h5e);
    $display("test strap done");
  endtask : t_strap
  initial begin
    repeat (6) @(negedge ref_clk_i);
    rst_i = 0;
    t_codes();
    t_b2b();
    t_hold();
    t_strap();
    finish_test();
  end
endmodule : mmb_bus_ctrl_test
